/* hdl/sac_pkg.sv */
// Constants, types and states shared by both ends of the attenuator link.
// Assumes one 20 MHz system clock on each end; no import is used.
//
// Overview of operation
// [RULE_01] Select low means parallel, high means serial
// [RULE_02] Six binary-weighted lines, 16 dB down to 0.5
// [RULE_03] Latched parallel: lines change with strobe low
// [RULE_04] Strobe held high: word follows lines directly
// [RULE_05] Parallel mode ignores serial data and clock
// [RULE_06] Six-bit shift register behind transparent latch
// [RULE_07] Shifting proceeds whatever the strobe level
// [RULE_08] Data sampled on serial clock rising edge
// [RULE_09] Serial word travels most significant bit first
// [RULE_10] Strobe high passes register, low holds it
// [RULE_11] Host shifts with strobe low, then pulses it
// [RULE_12] Serial power-up loads word from parallel lines
// [RULE_13] Parallel power-up, strobe low: preset pins pick
// [RULE_14] Parallel power-up, strobe high: lines pick word
// [RULE_15] Host serial clock no faster than 10 MHz
// [RULE_16] Serial bits weigh as lines, 16 dB first
package sac_pkg;
    localparam int WORD_W = 6;
    localparam int SYNC_STAGES = 2;
    localparam int CNT_W = 8;
    // Bit positions of the weights within the attenuation word
    localparam int BIT_16DB = 5;
    localparam int BIT_8DB = 4;
    localparam int BIT_4DB = 3;
    localparam int BIT_2DB = 2;
    localparam int BIT_1DB = 1;
    localparam int BIT_HALF_DB = 0;
    // Power-up presets chosen by the two preset select pins
    localparam logic [WORD_W-1:0] PRESET_REF = 6'h00;
    localparam logic [WORD_W-1:0] PRESET_8DB = 6'h10;
    localparam logic [WORD_W-1:0] PRESET_16DB = 6'h20;
    localparam logic [WORD_W-1:0] PRESET_31P5DB = 6'h3F;
    localparam logic [WORD_W-1:0] WORD_RESET = 6'h00;
    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int SCLK_MAX_MHZ = 10;
    localparam int T_SCLK_HALF_NS = 1000 / (2 * SCLK_MAX_MHZ);
    localparam int T_SER_LEPW_NS = 30;
    localparam int T_LESUP_NS = 10;
    localparam int T_PAR_LEPW_NS = 10;
    localparam int T_PDSUP_NS = 10;
    localparam int T_PDHLD_NS = 10;
    localparam logic [CNT_W-1:0] SCLK_HALF_CYC =
        CNT_W'((T_SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] SER_LEPW_CYC =
        CNT_W'((T_SER_LEPW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] LESUP_CYC =
        CNT_W'((T_LESUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] PAR_LEPW_CYC =
        CNT_W'((T_PAR_LEPW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] PDSUP_CYC =
        CNT_W'((T_PDSUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] PDHLD_CYC =
        CNT_W'((T_PDHLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] SETTLE_CYC = 8'h02;
    localparam logic [2:0] LAST_BIT = 3'h5;
    // Host registers on Wishbone
    localparam int ADR_W = 4;
    localparam logic [ADR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADR_W-1:0] ADDR_WORD = 4'h4;
    localparam logic [ADR_W-1:0] ADDR_STATUS = 4'h8;
    localparam int CTRL_SERIAL_BIT = 0;
    localparam int CTRL_DIRECT_BIT = 1;
    localparam int CTRL_PRESET_UP_BIT = 2;
    localparam int CTRL_PRESET_LO_BIT = 3;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_CNT_LSB = 8;
    typedef enum logic [2:0] {
        DEV_SETTLE = 3'h1,
        DEV_INIT = 3'h2,
        DEV_RUN = 3'h4
    } sac_dev_st_t;
    typedef enum logic [7:0] {
        HST_IDLE = 8'h01,
        HST_PAR_SETUP = 8'h02,
        HST_PAR_PULSE = 8'h04,
        HST_PAR_HOLD = 8'h08,
        HST_SER_LOW = 8'h10,
        HST_SER_HIGH = 8'h20,
        HST_SER_LESUP = 8'h40,
        HST_SER_PULSE = 8'h80
    } sac_hst_st_t;
endpackage : sac_pkg

/* hdl/sac_link_if.sv */
// Control pins between the host controller and the step attenuator.
// Host drives every pin; the device only samples them.
`timescale 1ns/1ps
`default_nettype none
interface sac_link_if;
    logic mode_serial;
    logic latch_strobe;
    logic weight_sixteen_db_line;
    logic weight_eight_db_line;
    logic weight_four_db_line;
    logic weight_two_db_line;
    logic weight_one_db_line;
    logic weight_half_db_line;
    logic preset_select_upper;
    logic preset_select_lower;
    logic serial_data;
    logic serial_clock;
    modport host (
        output mode_serial, latch_strobe,
        output weight_sixteen_db_line, weight_eight_db_line,
        output weight_four_db_line, weight_two_db_line,
        output weight_one_db_line, weight_half_db_line,
        output preset_select_upper, preset_select_lower,
        output serial_data, serial_clock
    );
    modport device (
        input mode_serial, latch_strobe,
        input weight_sixteen_db_line, weight_eight_db_line,
        input weight_four_db_line, weight_two_db_line,
        input weight_one_db_line, weight_half_db_line,
        input preset_select_upper, preset_select_lower,
        input serial_data, serial_clock
    );
endinterface : sac_link_if
`default_nettype wire

/* hdl/sac_device.sv */
// Digital control logic of the six-bit step attenuator.
// Assumes all link pins are asynchronous to clk_i; rst_i stands for
// power-up and is synchronous, active high.
`timescale 1ns/1ps
`default_nettype none
module sac_device (
    input wire logic clk_i,
    input wire logic rst_i,
    sac_link_if.device link,
    output logic [sac_pkg::WORD_W-1:0] atten_word_o,
    output logic ready_o,
    output logic serial_mode_o,
    output logic transparent_o
);
    localparam int W = sac_pkg::WORD_W;
    localparam int S = sac_pkg::SYNC_STAGES;

    typedef struct packed {
        logic [S-1:0] mode_sy;
        logic [S-1:0] strobe_sy;
        logic [S-1:0] sclk_sy;
        logic [S-1:0] sdat_sy;
        logic [S-1:0] pup_sy;
        logic [S-1:0] plo_sy;
        logic [S-1:0][W-1:0] par_sy;
        logic sclk_prev;
        logic [W-1:0] shift;
        logic [W-1:0] word;
        logic [sac_pkg::CNT_W-1:0] settle;
        logic serial;
        logic transp;
        sac_pkg::sac_dev_st_t st;
    } sac_dev_state_t;

    sac_dev_state_t cur_reg;
    sac_dev_state_t cur_next;

    logic [W-1:0] pin_word;
    logic mode_s;
    logic strobe_s;
    logic sclk_s;
    logic sdat_s;
    logic pup_s;
    logic plo_s;
    logic [W-1:0] par_s;
    logic sclk_rise;

    // Gather the six weight lines into one word, 16 dB on top
    always_comb begin // see RULE_02
        pin_word = '0;
        pin_word[sac_pkg::BIT_16DB] = link.weight_sixteen_db_line;
        pin_word[sac_pkg::BIT_8DB] = link.weight_eight_db_line;
        pin_word[sac_pkg::BIT_4DB] = link.weight_four_db_line;
        pin_word[sac_pkg::BIT_2DB] = link.weight_two_db_line;
        pin_word[sac_pkg::BIT_1DB] = link.weight_one_db_line;
        pin_word[sac_pkg::BIT_HALF_DB] = link.weight_half_db_line;
    end

    // Only the last synchroniser stage is read by any logic
    assign mode_s = cur_reg.mode_sy[S-1];
    assign strobe_s = cur_reg.strobe_sy[S-1];
    assign sclk_s = cur_reg.sclk_sy[S-1];
    assign sdat_s = cur_reg.sdat_sy[S-1];
    assign pup_s = cur_reg.pup_sy[S-1];
    assign plo_s = cur_reg.plo_sy[S-1];
    assign par_s = cur_reg.par_sy[S-1];
    assign sclk_rise = sclk_s & ~cur_reg.sclk_prev; // see RULE_08

    always_comb begin
        cur_next = cur_reg;

        // Two-stage synchronisers for every pin
        cur_next.mode_sy = {cur_reg.mode_sy[S-2:0], link.mode_serial};
        cur_next.strobe_sy = {cur_reg.strobe_sy[S-2:0], link.latch_strobe};
        cur_next.sclk_sy = {cur_reg.sclk_sy[S-2:0], link.serial_clock};
        cur_next.sdat_sy = {cur_reg.sdat_sy[S-2:0], link.serial_data};
        cur_next.pup_sy = {cur_reg.pup_sy[S-2:0],
                           link.preset_select_upper};
        cur_next.plo_sy = {cur_reg.plo_sy[S-2:0],
                           link.preset_select_lower};
        cur_next.par_sy = {cur_reg.par_sy[S-2:0], pin_word};

        // Edge history tracks the clock in every state, so no false
        // edge is seen when running starts
        cur_next.sclk_prev = sclk_s;
        cur_next.serial = mode_s;
        cur_next.transp = strobe_s;

        case (cur_reg.st)
            sac_pkg::DEV_SETTLE: begin
                // Wait until the synchronisers hold real pin levels
                if (cur_reg.settle == sac_pkg::SETTLE_CYC - 8'h01) begin
                    cur_next.st = sac_pkg::DEV_INIT;
                end else begin
                    cur_next.settle = cur_reg.settle + 8'h01;
                end
            end
            sac_pkg::DEV_INIT: begin
                if (mode_s) begin
                    // Serial power-up: any of the 64 words from the lines
                    cur_next.word = par_s; // see RULE_12
                    cur_next.shift = par_s; // see RULE_12
                end else if (strobe_s) begin
                    // Strobe high: presets inactive, lines decide
                    cur_next.word = par_s; // see RULE_14
                end else begin
                    case ({pup_s, plo_s}) // see RULE_13
                        2'h0: begin
                            cur_next.word = sac_pkg::PRESET_REF;
                        end
                        2'h1: begin
                            cur_next.word = sac_pkg::PRESET_8DB;
                        end
                        2'h2: begin
                            cur_next.word = sac_pkg::PRESET_16DB;
                        end
                        default: begin
                            cur_next.word = sac_pkg::PRESET_31P5DB;
                        end
                    endcase
                end
                cur_next.st = sac_pkg::DEV_RUN;
            end
            sac_pkg::DEV_RUN: begin
                if (mode_s) begin // see RULE_01
                    // Shifting is never gated by the strobe
                    if (sclk_rise) begin // see RULE_07
                        // MSB first: first bit ends at the 16 dB place
                        cur_next.shift = {cur_reg.shift[W-2:0],
                                          sdat_s}; // see RULE_09, RULE_16
                    end
                    // Transparent latch between register and attenuator
                    if (strobe_s) begin // see RULE_10
                        cur_next.word = cur_next.shift; // see RULE_06
                    end
                end else begin
                    // Serial data and clock are not looked at here
                    if (strobe_s) begin // see RULE_05
                        // Strobe high follows lines; falling holds last
                        cur_next.word = par_s; // see RULE_03, RULE_04
                    end
                end
            end
            default: begin
                cur_next.st = sac_pkg::DEV_SETTLE;
                cur_next.settle = '0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur_reg <= '0;
            cur_reg.word <= sac_pkg::WORD_RESET;
            cur_reg.st <= sac_pkg::DEV_SETTLE;
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign atten_word_o = cur_reg.word;
    assign ready_o = (cur_reg.st == sac_pkg::DEV_RUN);
    assign serial_mode_o = cur_reg.serial;
    assign transparent_o = cur_reg.transp;
endmodule : sac_device
`default_nettype wire

/* hdl/sac_host.sv */
// Host controller that programs the attenuator over its control pins.
// Software reaches it as a classic Wishbone slave on clk_i.
//
// Decided for this implementation: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sac_host #(
    parameter logic [sac_pkg::CNT_W-1:0] SCLK_HALF = sac_pkg::SCLK_HALF_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [sac_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    sac_link_if.host link
);
    localparam int W = sac_pkg::WORD_W;
    localparam int C = sac_pkg::CNT_W;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic serial;
        logic direct;
        logic pup;
        logic plo;
        logic [W-1:0] word;
        logic [W-1:0] par;
        logic [W-1:0] shift;
        logic strobe;
        logic sclk;
        logic sdat;
        logic [C-1:0] cnt;
        logic [2:0] bits;
        logic [7:0] xfers;
        sac_pkg::sac_hst_st_t st;
    } sac_hst_state_t;

    sac_hst_state_t cur_reg;
    sac_hst_state_t cur_next;
    logic req;
    logic idle;

    assign req = wb_cyc_i & wb_stb_i & ~cur_reg.ack;
    assign idle = (cur_reg.st == sac_pkg::HST_IDLE);

    always_comb begin
        cur_next = cur_reg;
        cur_next.ack = req;
        cur_next.rdata = '0;
        if (req & ~wb_we_i) begin
            case (wb_adr_i)
                sac_pkg::ADDR_CTRL: begin
                    cur_next.rdata[sac_pkg::CTRL_SERIAL_BIT] = cur_reg.serial;
                    cur_next.rdata[sac_pkg::CTRL_DIRECT_BIT] = cur_reg.direct;
                    cur_next.rdata[sac_pkg::CTRL_PRESET_UP_BIT] = cur_reg.pup;
                    cur_next.rdata[sac_pkg::CTRL_PRESET_LO_BIT] = cur_reg.plo;
                end
                sac_pkg::ADDR_WORD: begin
                    cur_next.rdata[W-1:0] = cur_reg.word;
                end
                sac_pkg::ADDR_STATUS: begin
                    cur_next.rdata[sac_pkg::STATUS_BUSY_BIT] = ~idle;
                    cur_next.rdata[sac_pkg::STATUS_CNT_LSB+:8] = cur_reg.xfers;
                end
                default: begin
                    cur_next.rdata = '0;
                end
            endcase
        end
        cur_next.cnt = cur_reg.cnt + 8'h01;
        case (cur_reg.st)
            sac_pkg::HST_IDLE: begin
                cur_next.cnt = '0;
                if (req & wb_we_i & wb_sel_i[0]) begin
                    if (wb_adr_i == sac_pkg::ADDR_CTRL) begin
                        cur_next.serial = wb_dat_i[sac_pkg::CTRL_SERIAL_BIT];
                        cur_next.direct = wb_dat_i[sac_pkg::CTRL_DIRECT_BIT];
                        cur_next.pup = wb_dat_i[sac_pkg::CTRL_PRESET_UP_BIT];
                        cur_next.plo = wb_dat_i[sac_pkg::CTRL_PRESET_LO_BIT];
                    end else if (wb_adr_i == sac_pkg::ADDR_WORD) begin
                        cur_next.word = wb_dat_i[W-1:0];
                        cur_next.xfers = cur_reg.xfers + 8'h01;
                        if (cur_reg.serial) begin // see RULE_01
                            cur_next.shift = wb_dat_i[W-1:0];
                            cur_next.sdat = wb_dat_i[W-1]; // see RULE_09
                            cur_next.bits = '0;
                            cur_next.st = sac_pkg::HST_SER_LOW;
                        end else if (cur_reg.direct) begin
                            cur_next.par = wb_dat_i[W-1:0]; // see RULE_04
                        end else begin
                            cur_next.par = wb_dat_i[W-1:0]; // see RULE_03
                            cur_next.st = sac_pkg::HST_PAR_SETUP;
                        end
                    end
                end
                // Idle strobe: high only for direct parallel use
                cur_next.strobe = cur_next.direct & ~cur_next.serial;
                if (cur_next.st != sac_pkg::HST_IDLE) begin
                    cur_next.strobe = 1'b0;
                end
            end
            sac_pkg::HST_PAR_SETUP: begin
                if (cur_reg.cnt == sac_pkg::PDSUP_CYC - 8'h01) begin
                    cur_next.strobe = 1'b1; // see RULE_03
                    cur_next.cnt = '0;
                    cur_next.st = sac_pkg::HST_PAR_PULSE;
                end
            end
            sac_pkg::HST_PAR_PULSE: begin
                if (cur_reg.cnt == sac_pkg::PAR_LEPW_CYC - 8'h01) begin
                    cur_next.strobe = 1'b0;
                    cur_next.cnt = '0;
                    cur_next.st = sac_pkg::HST_PAR_HOLD;
                end
            end
            sac_pkg::HST_PAR_HOLD: begin
                if (cur_reg.cnt == sac_pkg::PDHLD_CYC - 8'h01) begin
                    cur_next.st = sac_pkg::HST_IDLE;
                end
            end
            sac_pkg::HST_SER_LOW: begin
                if (cur_reg.cnt == SCLK_HALF - 8'h01) begin // see RULE_15
                    cur_next.sclk = 1'b1; // see RULE_08
                    cur_next.cnt = '0;
                    cur_next.st = sac_pkg::HST_SER_HIGH;
                end
            end
            sac_pkg::HST_SER_HIGH: begin
                if (cur_reg.cnt == SCLK_HALF - 8'h01) begin // see RULE_15
                    // Data moves only on the falling edge
                    cur_next.sclk = 1'b0; // see RULE_08
                    cur_next.cnt = '0;
                    if (cur_reg.bits == sac_pkg::LAST_BIT) begin
                        cur_next.st = sac_pkg::HST_SER_LESUP;
                    end else begin
                        cur_next.bits = cur_reg.bits + 3'h1;
                        cur_next.shift = {cur_reg.shift[W-2:0], 1'b0};
                        cur_next.sdat = cur_reg.shift[W-2]; // see RULE_16
                        cur_next.st = sac_pkg::HST_SER_LOW;
                    end
                end
            end
            sac_pkg::HST_SER_LESUP: begin
                if (cur_reg.cnt == sac_pkg::LESUP_CYC - 8'h01) begin
                    cur_next.strobe = 1'b1; // see RULE_11
                    cur_next.cnt = '0;
                    cur_next.st = sac_pkg::HST_SER_PULSE;
                end
            end
            sac_pkg::HST_SER_PULSE: begin
                if (cur_reg.cnt == sac_pkg::SER_LEPW_CYC - 8'h01) begin
                    cur_next.strobe = 1'b0; // see RULE_11
                    cur_next.st = sac_pkg::HST_IDLE;
                end
            end
            default: begin
                cur_next.st = sac_pkg::HST_IDLE;
                cur_next.strobe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur_reg <= '0;
            cur_reg.par <= sac_pkg::WORD_RESET;
            cur_reg.st <= sac_pkg::HST_IDLE;
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign wb_ack_o = cur_reg.ack;
    assign wb_dat_o = cur_reg.rdata;
    assign link.mode_serial = cur_reg.serial;
    assign link.latch_strobe = cur_reg.strobe;
    assign link.weight_sixteen_db_line = cur_reg.par[sac_pkg::BIT_16DB];
    assign link.weight_eight_db_line = cur_reg.par[sac_pkg::BIT_8DB];
    assign link.weight_four_db_line = cur_reg.par[sac_pkg::BIT_4DB];
    assign link.weight_two_db_line = cur_reg.par[sac_pkg::BIT_2DB];
    assign link.weight_one_db_line = cur_reg.par[sac_pkg::BIT_1DB];
    assign link.weight_half_db_line = cur_reg.par[sac_pkg::BIT_HALF_DB];
    assign link.preset_select_upper = cur_reg.pup;
    assign link.preset_select_lower = cur_reg.plo;
    assign link.serial_data = cur_reg.sdat;
    assign link.serial_clock = cur_reg.sclk;
endmodule : sac_host
`default_nettype wire

/* bench/sac_link_props.sv */
// Assertions on the link pins between host and attenuator and on the
// attenuator's word output. Instantiated beside the link interface.
`timescale 1ns/1ps
`default_nettype none
module sac_link_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic mode_serial,
    input wire logic latch_strobe,
    input wire logic weight_sixteen_db_line,
    input wire logic weight_eight_db_line,
    input wire logic weight_four_db_line,
    input wire logic weight_two_db_line,
    input wire logic weight_one_db_line,
    input wire logic weight_half_db_line,
    input wire logic preset_select_upper,
    input wire logic preset_select_lower,
    input wire logic serial_data,
    input wire logic serial_clock,
    input wire logic [sac_pkg::WORD_W-1:0] atten_word_o,
    input wire logic ready_o
);
    logic [5:0] lines;
    logic [5:0] preset_word;
    logic sclk_q;
    logic [7:0] rise_gap;
    assign lines = {weight_sixteen_db_line, weight_eight_db_line,
        weight_four_db_line, weight_two_db_line, weight_one_db_line,
        weight_half_db_line};
    always_comb begin
        case ({preset_select_upper, preset_select_lower})
            2'h0: preset_word = 6'h00;
            2'h1: preset_word = 6'h10;
            2'h2: preset_word = 6'h20;
            default: preset_word = 6'h3F;
        endcase
    end
    // Cycles since the previous serial clock rise, saturating
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sclk_q <= 1'b0;
            rise_gap <= 8'hFF;
        end else begin
            sclk_q <= serial_clock;
            if (serial_clock && !sclk_q)
                rise_gap <= 8'h01;
            else if (rise_gap != 8'hFF)
                rise_gap <= rise_gap + 8'h01;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    word_hold_a: assert property (
        (ready_o && !latch_strobe && $stable(mode_serial))[*5]
        |-> $stable(atten_word_o)) else $error("word moved, strobe low");
    direct_follow_a: assert property (
        (ready_o && !mode_serial && latch_strobe && $stable(lines))[*6]
        |-> atten_word_o == lines) else $error("word not following lines");
    sdat_stable_a: assert property (
        (serial_clock && !sclk_q) |-> $stable(serial_data) ##1
        $stable(serial_data)) else $error("data moved at clock rise");
    sclk_rate_a: assert property (
        (serial_clock && !sclk_q) |-> rise_gap >= 8'h02)
        else $error("serial clock too fast");
    par_setup_a: assert property (
        ($rose(latch_strobe) || $fell(latch_strobe)) && !mode_serial
        |-> $stable(lines)) else $error("lines moved at strobe edge");
    ser_strobe_a: assert property (
        mode_serial && serial_clock |-> !latch_strobe)
        else $error("strobe high while shifting");
    preset_pick_a: assert property (
        $rose(ready_o) && !mode_serial && !latch_strobe
        |-> ##1 atten_word_o == preset_word) else $error("wrong preset");
    powerup_lines_a: assert property (
        $rose(ready_o) && (mode_serial || latch_strobe)
        |-> ##1 atten_word_o == lines) else $error("wrong power-up word");
endmodule : sac_link_props
`default_nettype wire

/* bench/step_attenuator_control_interface_tb_top.sv */
// Bench: host and attenuator joined by the link, host driven over Wishbone.
// Assumes the package and both design ends are compiled first.
`timescale 1ns/1ps
`default_nettype none
module step_attenuator_control_interface_tb_top;
    logic clk = 1'b0, rst_host = 1'b1, rst_dev = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, ready, smode, transp;
    logic [3:0] adr = 4'h0, sel = 4'h0, ctrl = 4'h0;
    logic [31:0] dat = 32'h0, dat_o, q, rnd = 32'hC6E75CBF;
    logic [5:0] word_o, last_par = 6'h00;
    int miscompares = 0, total_checks = 0, writes = 0;
    int exp_q[$];
    always #25 clk = ~clk;
    sac_link_if link();
    sac_host #(.SCLK_HALF(8'h04)) i_sac_host (.clk_i(clk), .rst_i(rst_host),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .link(link));
    sac_device i_sac_device (.clk_i(clk), .rst_i(rst_dev), .link(link),
        .atten_word_o(word_o), .ready_o(ready), .serial_mode_o(smode),
        .transparent_o(transp));
    sac_link_props i_sac_link_props (.clk_i(clk),
        .rst_i(rst_host || rst_dev), .mode_serial(link.mode_serial),
        .latch_strobe(link.latch_strobe),
        .weight_sixteen_db_line(link.weight_sixteen_db_line),
        .weight_eight_db_line(link.weight_eight_db_line),
        .weight_four_db_line(link.weight_four_db_line),
        .weight_two_db_line(link.weight_two_db_line),
        .weight_one_db_line(link.weight_one_db_line),
        .weight_half_db_line(link.weight_half_db_line),
        .preset_select_upper(link.preset_select_upper),
        .preset_select_lower(link.preset_select_lower),
        .serial_data(link.serial_data), .serial_clock(link.serial_clock),
        .atten_word_o(word_o), .ready_o(ready));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic check(input string name, input logic [31:0] seen,
            input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wb(input logic w, input logic [3:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        dat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 100);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 100) check("wb_ack", {31'h0, ack}, 32'h1);
    endtask : wb
    task automatic send(input logic [5:0] w);
        int n;
        n = 0;
        wb(1'b1, sac_pkg::ADDR_WORD, {26'h0, w});
        writes++;
        exp_q.push_back(int'(w));
        if (!ctrl[0]) last_par = w;
        do begin
            wb(1'b0, sac_pkg::ADDR_STATUS, 32'h0);
            n++;
        end while (q[0] !== 1'b0 && n < 200);
        if (n >= 200) check("busy_clear", {31'h0, q[0]}, 32'h0);
        repeat (6) @(posedge clk);
        check("atten_word", {26'h0, word_o}, 32'(exp_q.pop_front()));
    endtask : send
    task automatic powerup(input logic [3:0] c, input logic [5:0] exp);
        int n;
        n = 0;
        ctrl = c;
        wb(1'b1, sac_pkg::ADDR_CTRL, {28'h0, c});
        @(posedge clk) rst_dev <= 1'b1;
        repeat (3) @(posedge clk);
        rst_dev <= 1'b0;
        while (ready !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        check("powerup_word", {26'h0, word_o}, {26'h0, exp});
        check("ready", {31'h0, ready}, 32'h1);
        check("serial_mode", {31'h0, smode}, {31'h0, c[0]});
        check("transparent", {31'h0, transp},
            {31'h0, c[1] & ~c[0]});
    endtask : powerup
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    initial begin
        #3000000;
        miscompares++;
        complete_run();
    end
    initial begin
        logic [1:0] p;
        repeat (4) @(posedge clk);
        rst_host <= 1'b0;
        rst_dev <= 1'b0;
        // Let the attenuator take its power-up word before any transfer
        repeat (5) @(posedge clk);
        check("ready", {31'h0, ready}, 32'h1);
        check("reset_word", {26'h0, word_o}, 32'h0);
        send(6'h3F);
        send(6'h01);
        repeat (3) begin
            rnd = lfsr(rnd);
            send(rnd[5:0]);
        end
        $display("test latched parallel done");
        for (int i = 0; i < 4; i++) begin
            p = 2'(i);
            // Preset weights in half-dB units: 0, 8, 16, 31.5 dB
            powerup({p[0], p[1], 2'b00},
                6'(i == 3 ? 63 : i * 16));
        end
        $display("test parallel presets done");
        powerup(4'h2, last_par);
        send(6'h2A);
        rnd = lfsr(rnd);
        send(rnd[5:0]);
        $display("test direct parallel done");
        powerup(4'h1, last_par);
        send(6'h20);
        send(6'h01);
        repeat (3) begin
            rnd = lfsr(rnd);
            send(rnd[5:0]);
        end
        $display("test serial done");
        powerup(4'h0, 6'h00);
        rnd = lfsr(rnd);
        send(rnd[5:0]);
        wb(1'b0, 4'hC, 32'h0);
        check("unmapped_read", q, 32'h0);
        wb(1'b0, sac_pkg::ADDR_STATUS, 32'h0);
        check("status", {16'h0, q[15:0]}, {16'h0, 8'(writes), 8'h00});
        $display("test registers done");
        complete_run();
    end
endmodule : step_attenuator_control_interface_tb_top
`default_nettype wire
